//--- common/ref_cfg_pkg.sv
// Package of register offsets, field positions, reset values and encodings for the reference block.
package ref_cfg_pkg;
   localparam logic [7:0]  addr_mode        = 8'h00;
   localparam logic [7:0]  addr_ref_select_pin      = 8'h08;
   localparam logic [7:0]  addr_inbuf       = 8'h60;
   localparam logic [7:0]  addr_refdiv      = 8'h64;
   localparam logic [7:0]  addr_bypass      = 8'h68;
   localparam logic [7:0]  addr_status      = 8'h6c;
   localparam int          zd_enable_bit    = 8;
   localparam int          zd_source_bit    = 10;
   localparam int          pri_buf_bit      = 15;
   localparam int          cap_lsb          = 8;
   localparam int          drive_lsb        = 2;
   localparam logic [15:0] mode_reset       = 16'h0000;
   localparam logic [1:0]  override_reset   = 2'h0;
   localparam logic [15:0] inbuf_reset      = 16'h0000;
   localparam logic [7:0]  refdiv_reset     = 8'h01;
   localparam logic [1:0]  bypass_reset     = 2'h0;
   localparam logic [1:0]  override_force_sec = 2'h2;
   localparam logic [1:0]  override_force_pri = 2'h3;
   localparam logic [1:0]  buf_crystal      = 2'h0;
   localparam logic [1:0]  buf_lvcmos       = 2'h1;
   localparam logic [1:0]  buf_diff         = 2'h2;
   localparam logic [7:0]  doubler_code     = 8'h00;
   localparam logic [31:0] status_err_data  = 32'h0000_0000;
endpackage : ref_cfg_pkg

//--- rtl/ref_path_decode.sv
// Combinational decoder from settings to reference path choices.
module ref_path_decode (
   input  wire logic       ref_select_pin_i,
   input  wire logic [1:0] ref_select_override_i,
   input  wire logic [1:0] secondary_buffer_type_i,
   input  wire logic       primary_buffer_type_i,
   input  wire logic       zero_delay_enable_i,
   input  wire logic       zero_delay_feedback_source_i,
   output logic            use_primary_o,
   output logic [1:0]      sec_buf_o,
   output logic [1:0]      pri_buf_o,
   output logic            sec_bias_o,
   output logic            pri_bias_o,
   output logic            ext_feedback_o,
   output logic            int_feedback_o
);
   function automatic logic [1:0] sec_kind(input logic [1:0] f);
      if (f == ref_cfg_pkg::buf_crystal) begin
         sec_kind = ref_cfg_pkg::buf_crystal;
      end else if (f == ref_cfg_pkg::buf_lvcmos) begin
         sec_kind = ref_cfg_pkg::buf_lvcmos;
      end else begin
         sec_kind = ref_cfg_pkg::buf_diff;
      end
   endfunction : sec_kind

   always_comb begin
      pri_buf_o = primary_buffer_type_i ? ref_cfg_pkg::buf_diff : ref_cfg_pkg::buf_lvcmos;
      ext_feedback_o = zero_delay_enable_i & zero_delay_feedback_source_i;
      int_feedback_o = zero_delay_enable_i & ~zero_delay_feedback_source_i;
      if (zero_delay_enable_i) begin
         use_primary_o = 1'b1;
      end else if (ref_select_override_i == ref_cfg_pkg::override_force_sec) begin
         use_primary_o = 1'b0;
      end else if (ref_select_override_i == ref_cfg_pkg::override_force_pri) begin
         use_primary_o = 1'b1;
      end else begin
         use_primary_o = ref_select_pin_i;
      end
      if (ext_feedback_o) begin
         sec_buf_o = pri_buf_o;
      end else begin
         sec_buf_o = sec_kind(secondary_buffer_type_i);
      end
      sec_bias_o = (sec_buf_o == ref_cfg_pkg::buf_diff);
      pri_bias_o = (pri_buf_o == ref_cfg_pkg::buf_diff);
   end
endmodule : ref_path_decode

//--- rtl/ref_select_ctrl.sv
// Reference input selection, buffer, divider and zero delay control with APB registers.
//
// Decided for this implementation: register access over APB and the register addresses.
module ref_select_ctrl (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ref_select_pin_i,
   output logic             use_primary_o,
   output logic [1:0]       sec_buf_o,
   output logic [1:0]       pri_buf_o,
   output logic             sec_bias_o,
   output logic             pri_bias_o,
   output logic             doubler_on_o,
   output logic [7:0]       ref_divider_value_o,
   output logic [4:0]       xtal_load_cap_o,
   output logic [3:0]       xtal_drive_o,
   output logic             bypass_enable_o,
   output logic             bypass_pfd_o,
   output logic             zero_delay_o,
   output logic             ext_feedback_o,
   output logic             int_feedback_o,
   output logic             chan2_keep_on_o
);
   typedef struct packed {
      logic [15:0] mode;
      logic [1:0]  override;
      logic [15:0] inbuf;
      logic [7:0]  refdiv;
      logic [1:0]  bypass;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        use_pri;
      logic [1:0]  sbuf;
      logic [1:0]  pbuf;
      logic        sbias;
      logic        pbias;
      logic        extfb;
      logic        intfb;
   } state_type;

   state_type state_ff;
   state_type nxt_state;
   logic      d_use_pri;
   logic [1:0] d_sbuf;
   logic [1:0] d_pbuf;
   logic      d_sbias;
   logic      d_pbias;
   logic      d_extfb;
   logic      d_intfb;
   logic      setup;
   logic      access;

   ref_path_decode u_decode (
      .ref_select_pin_i             (ref_select_pin_i),
      .ref_select_override_i        (state_ff.override),
      .secondary_buffer_type_i      (state_ff.inbuf[1:0]),
      .primary_buffer_type_i        (state_ff.inbuf[ref_cfg_pkg::pri_buf_bit]),
      .zero_delay_enable_i          (state_ff.mode[ref_cfg_pkg::zd_enable_bit]),
      .zero_delay_feedback_source_i (state_ff.mode[ref_cfg_pkg::zd_source_bit]),
      .use_primary_o                (d_use_pri),
      .sec_buf_o                    (d_sbuf),
      .pri_buf_o                    (d_pbuf),
      .sec_bias_o                   (d_sbias),
      .pri_bias_o                   (d_pbias),
      .ext_feedback_o               (d_extfb),
      .int_feedback_o               (d_intfb)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register bus and state update.
   assign setup  = psel & ~penable;
   assign access = psel & penable & state_ff.ready;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.ready = setup;
      nxt_state.use_pri = d_use_pri;
      nxt_state.sbuf = d_sbuf;
      nxt_state.pbuf = d_pbuf;
      nxt_state.sbias = d_sbias;
      nxt_state.pbias = d_pbias;
      nxt_state.extfb = d_extfb;
      nxt_state.intfb = d_intfb;
      if (setup) begin
         nxt_state.err = 1'b0;
         nxt_state.rdata = ref_cfg_pkg::status_err_data;
         case (paddr)
            ref_cfg_pkg::addr_mode:   nxt_state.rdata = {16'h0000, state_ff.mode};
            ref_cfg_pkg::addr_ref_select_pin: nxt_state.rdata = {30'h0000_0000, state_ff.override};
            ref_cfg_pkg::addr_inbuf:  nxt_state.rdata = {16'h0000, state_ff.inbuf};
            ref_cfg_pkg::addr_refdiv: nxt_state.rdata = {24'h00_0000, state_ff.refdiv};
            ref_cfg_pkg::addr_bypass: nxt_state.rdata = {30'h0000_0000, state_ff.bypass};
            ref_cfg_pkg::addr_status: nxt_state.rdata = {24'h00_0000, state_ff.intfb,
               state_ff.extfb, state_ff.pbias, state_ff.sbias, state_ff.pbuf[1],
               state_ff.sbuf, state_ff.use_pri};
            default: nxt_state.err = 1'b1;
         endcase
         if (pwrite && paddr == ref_cfg_pkg::addr_status) begin
            nxt_state.err = 1'b1;
         end
      end
      if (access && pwrite && !state_ff.err) begin
         case (paddr)
            ref_cfg_pkg::addr_mode:   nxt_state.mode = pwdata[15:0];
            ref_cfg_pkg::addr_ref_select_pin: nxt_state.override = pwdata[1:0];
            ref_cfg_pkg::addr_inbuf:  nxt_state.inbuf = pwdata[15:0];
            ref_cfg_pkg::addr_refdiv: nxt_state.refdiv = pwdata[7:0];
            ref_cfg_pkg::addr_bypass: nxt_state.bypass = pwdata[1:0];
            default: nxt_state.mode = state_ff.mode;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= '{mode: ref_cfg_pkg::mode_reset, override: ref_cfg_pkg::override_reset,
                       inbuf: ref_cfg_pkg::inbuf_reset, refdiv: ref_cfg_pkg::refdiv_reset,
                       bypass: ref_cfg_pkg::bypass_reset, rdata: 32'h0000_0000,
                       ready: 1'b0, err: 1'b0, use_pri: 1'b0, sbuf: 2'h0, pbuf: 2'h1,
                       sbias: 1'b0, pbias: 1'b0, extfb: 1'b0, intfb: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs from flip-flops; pslverr, doubler_on_o and zero_delay_o pass through a gate or compare first.
   assign prdata              = state_ff.rdata;
   assign pready              = state_ff.ready;
   assign pslverr             = state_ff.ready & state_ff.err;
   assign use_primary_o       = state_ff.use_pri;
   assign sec_buf_o           = state_ff.sbuf;
   assign pri_buf_o           = state_ff.pbuf;
   assign sec_bias_o          = state_ff.sbias;
   assign pri_bias_o          = state_ff.pbias;
   assign doubler_on_o        = (state_ff.refdiv == ref_cfg_pkg::doubler_code);
   assign ref_divider_value_o = state_ff.refdiv;
   assign xtal_load_cap_o     = state_ff.inbuf[ref_cfg_pkg::cap_lsb +: 5];
   assign xtal_drive_o        = state_ff.inbuf[ref_cfg_pkg::drive_lsb +: 4];
   assign bypass_enable_o     = state_ff.bypass[0];
   assign bypass_pfd_o        = state_ff.bypass[1];
   assign zero_delay_o        = state_ff.extfb | state_ff.intfb;
   assign ext_feedback_o      = state_ff.extfb;
   assign int_feedback_o      = state_ff.intfb;
   assign chan2_keep_on_o     = state_ff.intfb;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   pin_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_ff.override < 2'h2 && !state_ff.mode[8])
      |=> use_primary_o == $past(ref_select_pin_i))
      else $error("pin selection not followed");
   force_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_ff.override[1] && !state_ff.mode[8]) |=> use_primary_o == $past(state_ff.override[0]))
      else $error("override not honoured");
   sec_buf_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!state_ff.mode[8] && state_ff.inbuf[1:0] == 2'h3) |=> sec_buf_o == 2'h2)
      else $error("secondary buffer decode wrong");
   pri_buf_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      pri_buf_o == ($past(state_ff.inbuf[15]) ? 2'h2 : 2'h1))
      else $error("primary buffer decode wrong");
   bias_match_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sec_bias_o == (sec_buf_o == 2'h2) && pri_bias_o == (pri_buf_o == 2'h2))
      else $error("bias does not match buffer");
   doubler_on_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      doubler_on_o == (ref_divider_value_o == 8'h00))
      else $error("doubler state wrong");
   zd_primary_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state_ff.mode[8] |=> use_primary_o)
      else $error("zero delay not on primary");
   zd_feedback_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $past(state_ff.mode[8]) |-> ext_feedback_o == $past(state_ff.mode[10]) &&
      int_feedback_o == !$past(state_ff.mode[10]) && chan2_keep_on_o == int_feedback_o)
      else $error("feedback source wrong");
   zd_match_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ext_feedback_o |-> sec_buf_o == pri_buf_o)
      else $error("secondary buffer does not match");
   bus_wait_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (psel && !penable) |=> pready)
      else $error("access phase not answered");
endmodule : ref_select_ctrl

//--- testbench/ref_strap_model.sv
// Board strap model that drives the reference selection pin.
module ref_strap_model (
   input  wire logic clk_i,
   input  wire logic level_i,
   output logic      ref_select_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ref_select_pin_o = 1'b0;
   // The strap settles one edge after a new level is asked for.
   always @(posedge clk_i) begin
      ref_select_pin_o <= level_i;
   end
endmodule : ref_strap_model

//--- testbench/reference_input_select_zero_delay_tb.sv
// Self-checking bench for the reference selection and zero delay control block.
module reference_input_select_zero_delay_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, level, pin, er;
   logic [7:0]  paddr, div_v;
   logic [31:0] pwdata, prdata, rd;
   logic [30:0] outs, e;
   logic [15:0] mode_v, buf_v;
   logic [1:0]  ov_v, byp_v;
   integer      seed;
   int          err_count, checked, cycles;
   ref_strap_model i_ref_strap_model (.clk_i(clk_i), .level_i(level), .ref_select_pin_o(pin));
   ref_select_ctrl i_ref_select_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ref_select_pin_i(pin), .use_primary_o(outs[30]),
      .sec_buf_o(outs[29:28]), .pri_buf_o(outs[27:26]), .sec_bias_o(outs[25]),
      .pri_bias_o(outs[24]), .doubler_on_o(outs[23]), .ref_divider_value_o(outs[22:15]),
      .xtal_load_cap_o(outs[14:10]), .xtal_drive_o(outs[9:6]), .bypass_enable_o(outs[5]),
      .bypass_pfd_o(outs[4]), .zero_delay_o(outs[3]), .ext_feedback_o(outs[2]),
      .int_feedback_o(outs[1]), .chan2_keep_on_o(outs[0]));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [30:0] expect_outs(input logic [15:0] m, input logic [1:0] ov,
         input logic [15:0] b, input logic [7:0] d, input logic [1:0] y, input logic p);
      logic zd, ext, up;
      logic [1:0] pb, sb;
      zd = m[8];
      ext = zd & m[10];
      up = zd ? 1'b1 : (ov == 2'h2) ? 1'b0 : (ov == 2'h3) ? 1'b1 : p;
      pb = b[15] ? 2'h2 : 2'h1;
      sb = ext ? pb : (b[1:0] == 2'h0) ? 2'h0 : (b[1:0] == 2'h1) ? 2'h1 : 2'h2;
      return {up, sb, pb, sb == 2'h2, pb == 2'h2, d == 8'h00, d, b[12:8], b[5:2], y[0], y[1],
              zd, ext, zd & ~m[10], zd & ~m[10]};
   endfunction : expect_outs
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int   n = 0;
      logic rdy;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         #1;
         rdy = (pready === 1'b1);
         rd  = prdata;
         er  = pslverr;
         @(posedge clk_i);
         n++;
      end while (!rdy && n < 50);
      if (!rdy) begin
         err_count++;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic print_verdict();
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial cycles = 0;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      seed = 5;
      err_count = 0;
      checked = 0;
      reset_n_i = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, level} = '0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(outs, expect_outs(16'h0, 2'h0, 16'h0, 8'h01, 2'h0, 1'b0));
      apb(1'b0, 8'h04, 32'h0);
      check({rd[30:0], er}, 32'h1);
      apb(1'b1, ref_cfg_pkg::addr_status, 32'hff);
      check({31'h0, er}, 32'h1);
      for (int i = 0; i < 48; i++) begin
         mode_v = $random(seed) & 16'h0500;
         ov_v   = 2'($random(seed));
         buf_v  = $random(seed) & 16'h9f3f;
         div_v  = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
         byp_v  = 2'($random(seed));
         level  <= 1'($random(seed));
         if (i < 32) begin
            ov_v   = i[1:0];
            mode_v = {5'h0, i[4], 1'b0, i[3], 8'h0};
            level  <= i[2];
         end
         apb(1'b1, ref_cfg_pkg::addr_mode, {16'h0, mode_v});
         apb(1'b1, ref_cfg_pkg::addr_ref_select_pin, {30'h0, ov_v});
         apb(1'b1, ref_cfg_pkg::addr_inbuf, {16'h0, buf_v});
         apb(1'b1, ref_cfg_pkg::addr_refdiv, {24'h0, div_v});
         apb(1'b1, ref_cfg_pkg::addr_bypass, {30'h0, byp_v});
         repeat (3) @(posedge clk_i);
         e = expect_outs(mode_v, ov_v, buf_v, div_v, byp_v, level);
         check(outs, e);
         apb(1'b0, ref_cfg_pkg::addr_status, 32'h0);
         check(rd, {24'h0, e[1], e[2], e[24], e[25], e[27], e[29:28], e[30]});
         apb(1'b0, ref_cfg_pkg::addr_inbuf, 32'h0);
         check(rd, {16'h0, buf_v});
         apb(1'b0, ref_cfg_pkg::addr_mode, 32'h0);
         check(rd, {16'h0, mode_v});
      end
      print_verdict();
   end
endmodule : reference_input_select_zero_delay_tb
